// >>> hw/intc_params.svh
`ifndef INTC_PARAMS_SVH
`define INTC_PARAMS_SVH

`define ADDR_ENABLE_LOW 16'h003A
`define ADDR_ENABLE_HIGH 16'h003B
`define ADDR_LATCH_LOW 16'h003C
`define ADDR_LATCH_HIGH 16'h003D
`define ADDR_SELECT 16'h003E

`define LATCH_COUNT 16
`define LEVEL_SHARED_FOUR 14
`define LEVEL_SHARED_FIVE 15
`define SEL_LEVEL16_BIT 0
`define SEL_LEVEL15_BIT 1

`define ENABLE_RESET 12'h000
`define SELECT_RESET 2'h0
`define VECTOR_TOP 16'hFFFE
`define STACK_FRAME 16'h0003
`define ACCEPT_CYCLES 8

`endif

// >>> hw/intc_pkg.sv
`default_nettype none
package intc_pkg;

  // special function register access from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  // stack and vector table access
  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_type;

  // values handed back to the core sequencer
  typedef struct packed {
    logic pc_load;
    logic [15:0] pc;
    logic sp_load;
    logic [15:0] sp;
    logic status_load;
    logic [6:0] status;
  } cpu_load_type;

  typedef enum {
    ST_IDLE,
    ST_CLEAR,
    ST_PUSH_STATUS,
    ST_PUSH_HIGH,
    ST_PUSH_LOW,
    ST_VEC_LOW,
    ST_VEC_HIGH,
    ST_VEC_WAIT,
    ST_LOAD,
    ST_POP_LOW,
    ST_POP_HIGH,
    ST_POP_STATUS,
    ST_RESTORE
  } seq_state_type;

endpackage : intc_pkg
`default_nettype wire

// >>> hw/pending_latch_bank.sv
`timescale 1ns/1ps
`default_nettype none
module pending_latch_bank #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] set_mask,
  input wire logic [WIDTH-1:0] clear_mask,
  output logic [WIDTH-1:0] latch
);

  logic [WIDTH-1:0] next_latch;

  // a request in the clearing cycle survives: set wins
  always_comb begin
    next_latch = (latch & ~clear_mask) | set_mask;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      latch <= '0;
    end else begin
      latch <= next_latch;
    end
  end

endmodule : pending_latch_bank
`default_nettype wire

// >>> hw/level_picker.sv
`timescale 1ns/1ps
`default_nettype none
module level_picker #(
  parameter int WIDTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic [WIDTH-1:0] eligible,
  output logic found,
  output logic [IDX_W-1:0] index
);

  // scan downward so the lowest level number is left standing
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        found = 1'b1;
        index = IDX_W'(i);
      end
    end
  end

endmodule : level_picker

// >>> hw/maskable_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "intc_params.svh"
module maskable_interrupt_controller (
  input wire logic clk,
  input wire logic resetn,
  // register access from the core
  input wire intc_pkg::sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  // dedicated request sources, one pulse per request
  input wire logic [13:2] source_request,
  input wire logic external_request_four,
  input wire logic external_request_five,
  input wire logic converter_done_request,
  // core sequencer
  input wire logic instr_last_cycle,
  input wire logic enable_instr,
  input wire logic disable_instr,
  input wire logic maskable_return_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic [6:0] processor_status_word,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_sp,
  output logic cpu_hold,
  output intc_pkg::cpu_load_type cpu_load,
  // stack and vector memory, read data one cycle after re
  output intc_pkg::mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  // status towards the core
  output logic master_enable_flag,
  output logic [3:0] accepted_level
);

  localparam int NL = `LATCH_COUNT;

  intc_pkg::seq_state_type state;
  intc_pkg::seq_state_type next_state;

  logic [15:4] source_enable_flag;
  logic [15:4] next_source_enable_flag;
  logic next_master_enable_flag;
  logic [1:0] shared_level_select;
  logic [1:0] next_shared_level_select;
  logic [3:0] next_accepted_level;
  logic [15:0] sp_base;
  logic [15:0] next_sp_base;
  logic [15:0] pc_save;
  logic [15:0] next_pc_save;
  logic [7:0] status_save;
  logic [7:0] next_status_save;
  logic [7:0] low_byte;
  logic [7:0] next_low_byte;
  logic [7:0] high_byte;
  logic [7:0] next_high_byte;
  logic [7:0] next_sfr_rdata;
  intc_pkg::cpu_load_type next_cpu_load;

  logic [NL-1:0] pending_latch;
  logic [NL-1:0] latch_set;
  logic [NL-1:0] latch_clear;
  logic [NL-1:0] eligible;
  logic pick_found;
  logic [3:0] pick_level;
  logic [15:0] vector_addr;
  logic wr_enable_low;
  logic wr_enable_high;
  logic wr_latch_low;
  logic wr_latch_high;
  logic wr_select;
  logic any_return;

  // register decode; writes only on the exact byte address
  assign wr_enable_low = sfr_req.wr && (sfr_req.addr == `ADDR_ENABLE_LOW);
  assign wr_enable_high = sfr_req.wr && (sfr_req.addr == `ADDR_ENABLE_HIGH);
  assign wr_latch_low = sfr_req.wr && (sfr_req.addr == `ADDR_LATCH_LOW);
  assign wr_latch_high = sfr_req.wr && (sfr_req.addr == `ADDR_LATCH_HIGH);
  assign wr_select = sfr_req.wr && (sfr_req.addr == `ADDR_SELECT);
  assign any_return = maskable_return_instr | nonmaskable_return_instr;

  // request routing; an unselected shared source is simply dropped
  always_comb begin
    latch_set = '0;
    latch_set[13:2] = source_request;
    latch_set[`LEVEL_SHARED_FOUR] = external_request_four &
                                    ~shared_level_select[`SEL_LEVEL15_BIT];
    latch_set[`LEVEL_SHARED_FIVE] = shared_level_select[`SEL_LEVEL16_BIT] ?
                                    converter_done_request :
                                    external_request_five;
  end

  // software clears by writing 0; a 1 leaves the latch alone and never sets it
  always_comb begin
    latch_clear = '0;
    if (wr_latch_low) begin
      latch_clear[7:0] = ~sfr_req.wdata;
    end
    if (wr_latch_high) begin
      latch_clear[15:8] = ~sfr_req.wdata;
    end
    if (state == intc_pkg::ST_CLEAR) begin
      latch_clear[accepted_level] = 1'b1;
    end
  end

  pending_latch_bank #(
    .WIDTH(NL)
  ) u_latches (
    .clk(clk),
    .resetn(resetn),
    .set_mask(latch_set),
    .clear_mask(latch_clear),
    .latch(pending_latch)
  );

  // levels 2 and 3 ignore every enable; levels 4..15 need both flags
  always_comb begin
    eligible = '0;
    eligible[3:2] = pending_latch[3:2];
    eligible[15:4] = pending_latch[15:4] & source_enable_flag &
                     {12{master_enable_flag}};
  end

  level_picker #(
    .WIDTH(NL),
    .IDX_W(4)
  ) u_picker (
    .eligible(eligible),
    .found(pick_found),
    .index(pick_level)
  );

  // each level owns one two-byte slot, counting down from the top
  assign vector_addr = `VECTOR_TOP - {11'h000, accepted_level, 1'b0};

  // sequencer is busy for the whole acceptance or return
  assign cpu_hold = (state != intc_pkg::ST_IDLE);

  // stack pushes walk down from the saved pointer, pops walk up
  always_comb begin
    mem_req = '0;
    case (state)
      intc_pkg::ST_PUSH_STATUS: begin
        mem_req.we = 1'b1;
        mem_req.addr = sp_base;
        mem_req.wdata = status_save;
      end
      intc_pkg::ST_PUSH_HIGH: begin
        mem_req.we = 1'b1;
        mem_req.addr = sp_base - 16'h0001;
        mem_req.wdata = pc_save[15:8];
      end
      intc_pkg::ST_PUSH_LOW: begin
        mem_req.we = 1'b1;
        mem_req.addr = sp_base - 16'h0002;
        mem_req.wdata = pc_save[7:0];
      end
      intc_pkg::ST_VEC_LOW: begin
        mem_req.re = 1'b1;
        mem_req.addr = vector_addr;
      end
      intc_pkg::ST_VEC_HIGH: begin
        mem_req.re = 1'b1;
        mem_req.addr = vector_addr + 16'h0001;
      end
      intc_pkg::ST_POP_LOW: begin
        mem_req.re = 1'b1;
        mem_req.addr = sp_base + 16'h0001;
      end
      intc_pkg::ST_POP_HIGH: begin
        mem_req.re = 1'b1;
        mem_req.addr = sp_base + 16'h0002;
      end
      intc_pkg::ST_POP_STATUS: begin
        mem_req.re = 1'b1;
        mem_req.addr = sp_base + `STACK_FRAME;
      end
      default: begin
        mem_req = '0;
      end
    endcase
  end

  // sequence and register next values
  always_comb begin
    next_state = state;
    next_master_enable_flag = master_enable_flag;
    next_source_enable_flag = source_enable_flag;
    next_shared_level_select = shared_level_select;
    next_accepted_level = accepted_level;
    next_sp_base = sp_base;
    next_pc_save = pc_save;
    next_status_save = status_save;
    next_low_byte = low_byte;
    next_high_byte = high_byte;
    next_cpu_load = '0;

    // software side; the core is held during a sequence so no overlap
    if (enable_instr) begin
      next_master_enable_flag = 1'b1;
    end
    if (disable_instr) begin
      next_master_enable_flag = 1'b0;
    end
    if (wr_enable_low) begin
      next_master_enable_flag = sfr_req.wdata[0];
      next_source_enable_flag[7:4] = sfr_req.wdata[7:4];
    end
    if (wr_enable_high) begin
      next_source_enable_flag[15:8] = sfr_req.wdata;
    end
    if (wr_select) begin
      // the reserved route on bit 1 is stored as written
      next_shared_level_select = sfr_req.wdata[1:0];
    end

    case (state)
      intc_pkg::ST_IDLE: begin
        if (any_return) begin
          next_sp_base = cpu_sp;
          next_state = intc_pkg::ST_POP_LOW;
        end else if (instr_last_cycle && pick_found) begin
          next_accepted_level = pick_level;
          next_sp_base = cpu_sp;
          next_pc_save = cpu_pc;
          next_state = intc_pkg::ST_CLEAR;
        end
      end
      intc_pkg::ST_CLEAR: begin
        // old flag is saved for the stack on the same edge that drops the live flag
        next_status_save = {processor_status_word, master_enable_flag};
        next_master_enable_flag = 1'b0;
        next_state = intc_pkg::ST_PUSH_STATUS;
      end
      intc_pkg::ST_PUSH_STATUS: begin
        next_state = intc_pkg::ST_PUSH_HIGH;
      end
      intc_pkg::ST_PUSH_HIGH: begin
        next_state = intc_pkg::ST_PUSH_LOW;
      end
      intc_pkg::ST_PUSH_LOW: begin
        next_state = intc_pkg::ST_VEC_LOW;
      end
      intc_pkg::ST_VEC_LOW: begin
        next_state = intc_pkg::ST_VEC_HIGH;
      end
      intc_pkg::ST_VEC_HIGH: begin
        next_low_byte = mem_rdata;
        next_state = intc_pkg::ST_VEC_WAIT;
      end
      intc_pkg::ST_VEC_WAIT: begin
        next_high_byte = mem_rdata;
        next_state = intc_pkg::ST_LOAD;
      end
      intc_pkg::ST_LOAD: begin
        // eighth cycle: counter and stack pointer handed over together
        next_cpu_load.pc_load = 1'b1;
        next_cpu_load.pc = {high_byte, low_byte};
        next_cpu_load.sp_load = 1'b1;
        next_cpu_load.sp = sp_base - `STACK_FRAME;
        next_state = intc_pkg::ST_IDLE;
      end
      intc_pkg::ST_POP_LOW: begin
        next_state = intc_pkg::ST_POP_HIGH;
      end
      intc_pkg::ST_POP_HIGH: begin
        next_low_byte = mem_rdata;
        next_state = intc_pkg::ST_POP_STATUS;
      end
      intc_pkg::ST_POP_STATUS: begin
        next_high_byte = mem_rdata;
        next_state = intc_pkg::ST_RESTORE;
      end
      intc_pkg::ST_RESTORE: begin
        // same restore for both return kinds
        next_master_enable_flag = mem_rdata[0];
        next_cpu_load.status_load = 1'b1;
        next_cpu_load.status = mem_rdata[7:1];
        next_cpu_load.pc_load = 1'b1;
        next_cpu_load.pc = {high_byte, low_byte};
        next_cpu_load.sp_load = 1'b1;
        next_cpu_load.sp = sp_base + `STACK_FRAME;
        next_state = intc_pkg::ST_IDLE;
      end
      default: begin
        next_state = intc_pkg::ST_IDLE;
      end
    endcase
  end

  // read data registered; unmapped addresses read zero
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_req.rd) begin
      case (sfr_req.addr)
        `ADDR_ENABLE_LOW: next_sfr_rdata = {source_enable_flag[7:4], 3'b000,
                                            master_enable_flag};
        `ADDR_ENABLE_HIGH: next_sfr_rdata = source_enable_flag[15:8];
        `ADDR_LATCH_LOW: next_sfr_rdata = pending_latch[7:0];
        `ADDR_LATCH_HIGH: next_sfr_rdata = pending_latch[15:8];
        `ADDR_SELECT: next_sfr_rdata = {6'h00, shared_level_select};
        default: next_sfr_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= intc_pkg::ST_IDLE;
      master_enable_flag <= 1'b0;
      source_enable_flag <= `ENABLE_RESET;
      shared_level_select <= `SELECT_RESET;
      accepted_level <= 4'h0;
      sp_base <= 16'h0000;
      pc_save <= 16'h0000;
      status_save <= 8'h00;
      low_byte <= 8'h00;
      high_byte <= 8'h00;
      sfr_rdata <= 8'h00;
      cpu_load <= '0;
    end else begin
      state <= next_state;
      master_enable_flag <= next_master_enable_flag;
      source_enable_flag <= next_source_enable_flag;
      shared_level_select <= next_shared_level_select;
      accepted_level <= next_accepted_level;
      sp_base <= next_sp_base;
      pc_save <= next_pc_save;
      status_save <= next_status_save;
      low_byte <= next_low_byte;
      high_byte <= next_high_byte;
      sfr_rdata <= next_sfr_rdata;
      cpu_load <= next_cpu_load;
    end
  end

endmodule : maskable_interrupt_controller
`default_nettype wire

// >>> dv/intc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module intc_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic maskable_return_instr,
  input wire logic nonmaskable_return_instr,
  input wire logic [15:0] cpu_pc,
  input wire logic [15:0] cpu_sp,
  input wire logic cpu_hold,
  input wire intc_pkg::cpu_load_type cpu_load,
  input wire intc_pkg::mem_req_type mem_req,
  input wire logic [7:0] mem_rdata,
  input wire logic master_enable_flag,
  input wire logic [3:0] accepted_level
);
  logic [7:0] rdata_q;

  // read data of the previous cycle, for the status restore check
  always_ff @(posedge clk) begin
    rdata_q <= mem_rdata;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // acceptance opens with a quiet clear cycle, a return with a stack read
  sequence acc_go;
    $rose(cpu_hold) && !mem_req.re;
  endsequence
  sequence ret_go;
    (maskable_return_instr || nonmaskable_return_instr) && !cpu_hold;
  endsequence

  accept_len_a: assert property (acc_go |-> cpu_hold [*8] ##1 !cpu_hold)
    else $error("acceptance length wrong");
  master_drop_a: assert property (acc_go |=> !master_enable_flag)
    else $error("master flag not cleared");
  push_order_a: assert property (acc_go |=> mem_req.we && mem_req.addr == cpu_sp
    && mem_req.wdata[0] == $past(master_enable_flag)
    ##1 mem_req.we && mem_req.addr == cpu_sp - 16'h0001 && mem_req.wdata == cpu_pc[15:8]
    ##1 mem_req.we && mem_req.addr == cpu_sp - 16'h0002 && mem_req.wdata == cpu_pc[7:0])
    else $error("push order wrong");
  vector_fetch_a: assert property (acc_go |-> ##4 mem_req.re
    && mem_req.addr == 16'hFFFE - {11'h000, accepted_level, 1'b0} ##1 mem_req.re)
    else $error("vector fetch wrong");
  mask_hold_a: assert property ($rose(cpu_hold) && !mem_req.re && !$past(master_enable_flag)
    |=> accepted_level < 4'h4)
    else $error("maskable taken with master clear");
  pop_order_a: assert property (ret_go |=> mem_req.re && mem_req.addr == cpu_sp + 16'h0001
    ##1 mem_req.re && mem_req.addr == cpu_sp + 16'h0002 ##1 cpu_hold [*2] ##1 !cpu_hold)
    else $error("return pop wrong");
  load_value_a: assert property ($fell(cpu_hold) |-> cpu_load.pc_load
    && cpu_load.pc == {$past(mem_rdata, 2), $past(mem_rdata, 3)})
    else $error("counter load wrong");
  // pointer as taken at the start edge; the core may move it once the load shows
  frame_a: assert property ($fell(cpu_hold) |-> cpu_load.sp_load && cpu_load.sp ==
    ($past(cpu_hold, 5) ? $past(cpu_sp, 9) - 16'h0003 : $past(cpu_sp, 5) + 16'h0003))
    else $error("stack frame size wrong");
  restore_a: assert property ($fell(cpu_hold) && !$past(cpu_hold, 5) |->
    cpu_load.status_load && cpu_load.status == rdata_q[7:1]
    && master_enable_flag == rdata_q[0])
    else $error("status restore wrong");

  cover property (acc_go);
  cover property (ret_go);
  cover property (acc_go ##1 accepted_level < 4'h4);
endmodule : intc_monitor

bind maskable_interrupt_controller intc_monitor i_intc_monitor (.clk(clk), .resetn(resetn),
  .maskable_return_instr(maskable_return_instr), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp),
  .nonmaskable_return_instr(nonmaskable_return_instr), .cpu_hold(cpu_hold),
  .cpu_load(cpu_load), .mem_req(mem_req), .mem_rdata(mem_rdata),
  .master_enable_flag(master_enable_flag), .accepted_level(accepted_level));
`default_nettype wire

// >>> dv/stack_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
module stack_memory_model (
  input wire logic clk,
  input wire intc_pkg::mem_req_type mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];

  // vector slots: low byte level*16, high byte A0+level, easy to recognise
  initial begin
    for (int lvl = 2; lvl < 16; lvl++) begin
      mem[16'hFFFE - 2 * lvl] = 8'(lvl << 4);
      mem[16'hFFFF - 2 * lvl] = 8'hA0 + 8'(lvl);
    end
    mem_rdata = 8'h00;
  end

  // answer one cycle after re; idle bus toggles so stale data never matches
  always @(posedge clk) begin
    if (mem_req.we) mem[mem_req.addr] <= mem_req.wdata;
    if (mem_req.re) mem_rdata <= mem[mem_req.addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule : stack_memory_model
`default_nettype wire

// >>> dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  intc_pkg::sfr_req_type sfr_req = '0;
  logic [7:0] sfr_rdata;
  logic [13:2] source_request = '0;
  logic external_request_four = 1'b0;
  logic external_request_five = 1'b0;
  logic converter_done_request = 1'b0;
  logic instr_last_cycle = 1'b0;
  logic enable_instr = 1'b0;
  logic disable_instr = 1'b0;
  logic maskable_return_instr = 1'b0;
  logic nonmaskable_return_instr = 1'b0;
  logic [6:0] processor_status_word = 7'h55;
  logic [15:0] cpu_pc = 16'h1234;
  logic [15:0] cpu_sp = 16'h01F0;
  logic cpu_hold;
  intc_pkg::cpu_load_type cpu_load;
  intc_pkg::mem_req_type mem_req;
  logic [7:0] mem_rdata;
  logic master_enable_flag;
  logic [3:0] accepted_level;
  int n_errors = 0;
  int comparisons = 0;

  // 25 MHz
  always #20 clk = ~clk;

  maskable_interrupt_controller i_maskable_interrupt_controller (.clk(clk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .source_request(source_request),
    .external_request_four(external_request_four), .cpu_hold(cpu_hold),
    .external_request_five(external_request_five), .cpu_pc(cpu_pc), .cpu_sp(cpu_sp),
    .converter_done_request(converter_done_request), .instr_last_cycle(instr_last_cycle),
    .enable_instr(enable_instr), .disable_instr(disable_instr), .cpu_load(cpu_load),
    .maskable_return_instr(maskable_return_instr), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .nonmaskable_return_instr(nonmaskable_return_instr), .accepted_level(accepted_level),
    .processor_status_word(processor_status_word), .master_enable_flag(master_enable_flag));
  stack_memory_model i_stack_memory_model (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // one register access; read data is registered, so compare a cycle later
  task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
    sfr_req = '{wr: w, rd: !w, addr: {8'h00, a}, wdata: d};
    tick(1);
    sfr_req = '0;
    // idle cycle so a following access never reassigns the strobe at once
    tick(1);
  endtask : sfr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr(1'b0, a, 8'h00);
    check(16'(sfr_rdata), 16'(exp), "register read");
  endtask : rd_chk

  // bounded wait for the counter load pulse
  task automatic wait_load();
    int k;
    for (k = 0; k < 12 && cpu_load.pc_load !== 1'b1; k++) tick(1);
    if (k == 12) begin
      n_errors++;
      $display("BAD %0t no counter load", $time);
      wrap_up();
    end
  endtask : wait_load

  task automatic accept(input logic [3:0] lvl);
    instr_last_cycle = 1'b1;
    tick(1);
    instr_last_cycle = 1'b0;
    wait_load();
    check(16'(accepted_level), 16'(lvl), "level");
    check(cpu_load.pc, {8'hA0 + 8'(lvl), lvl, 4'h0}, "vector");
    check(cpu_load.sp, 16'h01ED, "stack after push");
    check(16'(master_enable_flag), 16'h0000, "master after accept");
  endtask : accept

  // return: frame sits at sp+1..sp+3, so hand over the pushed pointer
  task automatic ret(input logic nm, input logic exp_master, input logic [15:0] exp_pc);
    cpu_sp = 16'h01ED;
    maskable_return_instr = !nm;
    nonmaskable_return_instr = nm;
    tick(1);
    maskable_return_instr = 1'b0;
    nonmaskable_return_instr = 1'b0;
    wait_load();
    check(cpu_load.pc, exp_pc, "return address");
    check(16'(cpu_load.status), 16'h0055, "status");
    check(16'(master_enable_flag), 16'(exp_master), "master restored");
    cpu_sp = 16'h01F0;
  endtask : ret

  task automatic t_reset();
    rd_chk(8'h3A, 8'h00);
    rd_chk(8'h3B, 8'h00);
    rd_chk(8'h3C, 8'h00);
    rd_chk(8'h3E, 8'h00);
    rd_chk(8'h3F, 8'h00);
  endtask : t_reset

  task automatic t_regs();
    sfr(1'b1, 8'h3B, 8'hA5);
    rd_chk(8'h3B, 8'hA5);
    sfr(1'b1, 8'h3A, 8'hF0);
    rd_chk(8'h3A, 8'hF0);
  endtask : t_regs

  // latch set, software cannot set, plain load clears with bits 2,3 at one
  task automatic t_latch();
    source_request[5] = 1'b1;
    tick(1);
    source_request = '0;
    tick(3);
    rd_chk(8'h3C, 8'h20);
    sfr(1'b1, 8'h3C, 8'hFF);
    rd_chk(8'h3C, 8'h20);
    sfr(1'b1, 8'h3C, 8'h0C);
    rd_chk(8'h3C, 8'h00);
  endtask : t_latch

  task automatic t_select();
    converter_done_request = 1'b1;
    tick(1);
    converter_done_request = 1'b0;
    rd_chk(8'h3D, 8'h00);
    sfr(1'b1, 8'h3E, 8'h01);
    rd_chk(8'h3E, 8'h01);
    external_request_five = 1'b1;
    tick(1);
    external_request_five = 1'b0;
    rd_chk(8'h3D, 8'h00);
    converter_done_request = 1'b1;
    external_request_four = 1'b1;
    tick(1);
    converter_done_request = 1'b0;
    external_request_four = 1'b0;
    rd_chk(8'h3D, 8'hC0);
    sfr(1'b1, 8'h3D, 8'h00);
    sfr(1'b1, 8'h3E, 8'h00);
  endtask : t_select

  task automatic t_accept();
    sfr(1'b1, 8'h3A, 8'h20);
    sfr(1'b1, 8'h3B, 8'h10);
    source_request[5] = 1'b1;
    source_request[12] = 1'b1;
    tick(1);
    source_request = '0;
    instr_last_cycle = 1'b1;
    tick(1);
    instr_last_cycle = 1'b0;
    tick(2);
    check(16'(cpu_hold), 16'h0000, "taken while masked");
    enable_instr = 1'b1;
    tick(1);
    enable_instr = 1'b0;
    accept(4'h5);
    rd_chk(8'h3C, 8'h00);
    rd_chk(8'h3D, 8'h10);
    // handler drops its own source flag before opening the master flag
    sfr(1'b1, 8'h3A, 8'h00);
    enable_instr = 1'b1;
    tick(1);
    enable_instr = 1'b0;
    rd_chk(8'h3A, 8'h01);
    ret(1'b0, 1'b1, 16'h1234);
    accept(4'hC);
    ret(1'b0, 1'b1, 16'h1234);
    disable_instr = 1'b1;
    source_request[2] = 1'b1;
    tick(1);
    disable_instr = 1'b0;
    source_request = '0;
    accept(4'h2);
    // trap handler moves its stacked return to a restart point
    i_stack_memory_model.mem[16'h01EE] = 8'h00;
    i_stack_memory_model.mem[16'h01EF] = 8'h40;
    ret(1'b1, 1'b0, 16'h4000);
  endtask : t_accept

  initial begin
    tick(2);
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_latch();
    t_select();
    t_accept();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
